// ==== shared/sst_pkg.sv ====
// constants and types shared by the sub-block sync tracker
package sst_pkg;
	// ----------------------------------------------------------------
	// stream geometry
	// ----------------------------------------------------------------
	localparam int          SYNC_W         = 16;
	localparam logic [15:0] SYNC_WORD      = 16'hE2B5;
	localparam int          BLOCK_BITS     = 512;
	localparam int          CNT_W          = 9;
	localparam int          WIN_BITS       = 8;
	localparam int          PREAMBLE_BLKS  = 8;
	// ----------------------------------------------------------------
	// acquisition and loss figures
	// ----------------------------------------------------------------
	localparam logic [1:0]  ACQ_HITS       = 2'h2;
	localparam logic [2:0]  ACQ_SPAN_BLKS  = 3'h7;
	localparam logic [2:0]  LOSS_MISSES    = 3'h5;
	// cycle after the last sync bit when the next expected sync ends
	localparam logic [8:0]  EXPECT_POS     = 9'h000;
	localparam logic [8:0]  WIN_LO         = 9'h1F8;
	localparam logic [8:0]  WIN_HI         = 9'h008;
	localparam logic [8:0]  CNT_LAST       = 9'h1FF;

	typedef enum logic [1:0] {SST_IDLE, SST_SEARCH, SST_CONFIRM,
		SST_LOCKED} sst_state_e;
endpackage

// ==== tb/sst_read_channel.sv ====
// read channel model: recovered bit stream and pll lock
`timescale 1ns/1ps
module sst_read_channel
	import sst_pkg::*;
(
	input  wire logic clk_sys,
	output logic      pllLock,
	output logic      bitValid,
	output logic      bitIn
);
	int seed = 11241;
	initial begin
		pllLock = 1'b0;
		bitValid = 1'b0;
		bitIn = 1'b0;
	end
	// ----
	// bit delivery
	// ----
	// random idle gaps; data toggles so a stale bit never lingers
	task automatic put_bit(input logic b);
		while (($random(seed) & 3) == 0) begin
			bitValid <= 1'b0;
			bitIn    <= ~bitIn;
			@(posedge clk_sys);
		end
		bitValid <= 1'b1;
		bitIn    <= b;
		@(posedge clk_sys);
	endtask
	// mode 0 clean, 1 one bit error, 2 error plus stray sync mid-block
	task automatic send_block(input int mode, input int pad);
		logic [15:0] w;
		w = SYNC_WORD;
		if (mode != 0)
			w[5] = ~w[5];
		repeat (pad) put_bit(1'b0);
		for (int i = SYNC_W - 1; i >= 0; i--)
			put_bit(w[i]);
		for (int i = 0; i < BLOCK_BITS - SYNC_W; i++) begin
			if (mode == 2 && i >= 200 && i < 216)
				put_bit(SYNC_WORD[215 - i]);
			else
				put_bit(1'b0);
		end
		bitValid <= 1'b0;
		bitIn    <= ~bitIn;
		@(posedge clk_sys);
	endtask
	// null sub-blocks led by sync; the pll locks after two of them
	task automatic preamble();
		repeat (2) send_block(0, 0);
		pllLock <= 1'b1;
		repeat (PREAMBLE_BLKS - 2) send_block(0, 0);
	endtask
	task automatic set_lock(input logic v);
		pllLock <= v;
		@(posedge clk_sys);
	endtask
endmodule

// ==== tb/test_subblock_sync_tracker.sv ====
// self-checking bench for the sub-block sync tracker
`timescale 1ns/1ps
module test_subblock_sync_tracker;
	import sst_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst_n = 1'b0;
	logic       defectSectorMap, rewriteAvail, addrFieldOk;
	logic       pllLock, bitValid, bitIn;
	logic       inSync, startDataSync, acqTimeout;
	logic       blockStart, syncLost, rewriteInsert;
	logic       prevSync = 1'b0;
	logic [1:0] r;
	logic [1:0] expQ[$];
	int         err_total = 0;
	int         total_checks = 0;
	int         nStart = 0;
	int         seed = 11241;
	always #10 clk_sys = ~clk_sys;
	sst_read_channel sst_read_channel_inst (.clk_sys(clk_sys),
		.pllLock(pllLock), .bitValid(bitValid), .bitIn(bitIn));
	sst_tracker sst_tracker_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.pllLock(pllLock), .bitValid(bitValid), .bitIn(bitIn),
		.defectSectorMap(defectSectorMap), .rewriteAvail(rewriteAvail),
		.addrFieldOk(addrFieldOk), .inSync(inSync),
		.startDataSync(startDataSync), .acqTimeout(acqTimeout),
		.blockStart(blockStart), .syncLost(syncLost),
		.rewriteInsert(rewriteInsert));
	// ----
	// checking
	// ----
	task automatic check(input logic [1:0] seen, input logic [1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// an event nobody announced compares against code zero
	task automatic take(input logic [1:0] code);
		logic [1:0] e;
		e = (expQ.size() > 0) ? expQ.pop_front() : 2'h0;
		check(code, e);
	endtask
	task automatic blk(input int mode, input int n);
		repeat (n) begin
			defectSectorMap <= 1'($random(seed));
			sst_read_channel_inst.send_block(mode, 0);
		end
	endtask
	task automatic bit1(input logic v, input logic exp);
		check({1'b0, v}, {1'b0, exp});
	endtask
	always @(posedge clk_sys) begin
		prevSync <= inSync;
		if (rst_n && inSync === 1'b1 && prevSync === 1'b0)
			take(2'h1);
		if (rst_n && syncLost === 1'b1)
			take(2'h2);
		if (rst_n && blockStart === 1'b1)
			nStart++;
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		err_total++;
		print_verdict();
	end
	// ----
	// scenarios
	// ----
	initial begin
		defectSectorMap = 1'b0;
		rewriteAvail = 1'b0;
		addrFieldOk = 1'b0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		// lock comes inside the preamble, so note it first
		expQ.push_back(2'h1);
		sst_read_channel_inst.preamble();
		blk(0, 3);
		bit1(inSync, 1'b1);
		bit1(startDataSync, 1'b1);
		bit1(acqTimeout, 1'b0);
		nStart = 0;
		fork
			blk(0, 1);
			repeat (20) begin
				r = 2'($random(seed));
				rewriteAvail <= r[0];
				addrFieldOk <= r[1];
				repeat (3) @(posedge clk_sys);
				bit1(rewriteInsert, r[0] & r[1]);
			end
		join
		check(2'(nStart), 2'h1);
		// four misses survive, the fifth drops lock
		blk(1, 4);
		blk(0, 1);
		expQ.push_back(2'h2);
		blk(1, 5);
		bit1(inSync, 1'b0);
		rewriteAvail <= 1'b1;
		addrFieldOk <= 1'b1;
		repeat (3) @(posedge clk_sys);
		bit1(rewriteInsert, 1'b0);
		// realign at an arbitrary offset over a mapped-out sector
		defectSectorMap <= 1'b1;
		sst_read_channel_inst.send_block(0, 37);
		expQ.push_back(2'h1);
		blk(0, 2);
		bit1(inSync, 1'b1);
		// stray syncs outside the window must not rescue the lock
		blk(2, 4);
		blk(0, 1);
		expQ.push_back(2'h2);
		blk(2, 5);
		bit1(inSync, 1'b0);
		// no sync within seven sub-blocks, then a late acquisition
		sst_read_channel_inst.set_lock(1'b0);
		sst_read_channel_inst.set_lock(1'b1);
		blk(1, 8);
		bit1(acqTimeout, 1'b1);
		bit1(startDataSync, 1'b0);
		sst_read_channel_inst.set_lock(1'b0);
		sst_read_channel_inst.set_lock(1'b1);
		blk(1, 4);
		expQ.push_back(2'h1);
		blk(0, 2);
		bit1(startDataSync, 1'b1);
		bit1(expQ.size() == 0, 1'b1);
		print_verdict();
	end
endmodule

// ==== verilog/sst_sync_match.sv ====
// sync word shifter and exact matcher
`timescale 1ns/1ps
module sst_sync_match
	import sst_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic bitValid,
	input  wire logic bitIn,
	output logic      syncHit
);
	import sst_pkg::*;

	logic [sst_pkg::SYNC_W-1:0] shiftReg;

	// ----------------------------------------------------------------
	// bit shifter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			shiftReg <= '0;
		end else if (bitValid) begin
			shiftReg <= {shiftReg[SYNC_W-2:0], bitIn};
		end
	end

	// exact compare: one bad bit means no sync
	assign syncHit = (shiftReg == SYNC_WORD);
endmodule

// ==== verilog/sst_tracker.sv ====
// sub-block sync acquisition and maintenance tracker
`timescale 1ns/1ps
module sst_tracker
	import sst_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic pllLock,
	input  wire logic bitValid,
	input  wire logic bitIn,
	input  wire logic defectSectorMap,
	input  wire logic rewriteAvail,
	input  wire logic addrFieldOk,
	output logic      inSync,
	output logic      startDataSync,
	output logic      acqTimeout,
	output logic      blockStart,
	output logic      syncLost,
	output logic      rewriteInsert
);
	import sst_pkg::*;

	sst_state_e state;
	logic [CNT_W-1:0] bitCnt;
	logic [2:0]       missCnt;
	logic [2:0]       spanCnt;
	logic             spanOpen;
	logic             syncHit;
	logic             winSeen;
	logic             blockSyncOk;
	logic             inWin;
	logic             accept;
	logic             boundary;

	// ----------------------------------------------------------------
	// matcher
	// ----------------------------------------------------------------
	sst_sync_match u_match (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.bitValid (bitValid),
		.bitIn    (bitIn),
		.syncHit  (syncHit)
	);

	// ----------------------------------------------------------------
	// window and acceptance
	// ----------------------------------------------------------------
	// window is one byte either side of expected end of sync word
	assign inWin = (bitCnt >= WIN_LO) || (bitCnt <= WIN_HI);
	assign accept = bitValid && syncHit &&
		((state != SST_LOCKED) || inWin);
	assign boundary = bitValid && (bitCnt == WIN_HI) &&
		(state == SST_LOCKED);

	// ----------------------------------------------------------------
	// bit position counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bitCnt <= '0;
		end else if (accept && state != SST_LOCKED) begin
			bitCnt <= 9'h001;
		end else if (bitValid) begin
			bitCnt <= bitCnt + 9'h001;
		end
	end

	// ----------------------------------------------------------------
	// acquisition state
	// ----------------------------------------------------------------
	// defect map is ignored on purpose: fill data still trains sync
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= SST_IDLE;
		end else if (!pllLock) begin
			state <= SST_IDLE;
		end else begin
			case (state)
				SST_IDLE: begin
					state <= SST_SEARCH;
				end
				SST_SEARCH: begin
					if (accept) begin
						state <= SST_CONFIRM;
					end
				end
				SST_CONFIRM: begin
					if (accept && bitCnt == EXPECT_POS) begin
						state <= SST_LOCKED;
					end else if (accept) begin
						state <= SST_CONFIRM;
					end else if (bitValid && bitCnt == EXPECT_POS) begin
						// second sync missed its slot: start over
						state <= SST_SEARCH;
					end
				end
				SST_LOCKED: begin
					// a sync on the last window bit still rescues the block
					if (boundary && !winSeen && !accept &&
						missCnt == LOSS_MISSES - 3'h1) begin
						state <= SST_SEARCH;
					end
				end
				default: state <= SST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// per sub-block sync check and miss count
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			winSeen <= 1'b0;
			missCnt <= '0;
			blockSyncOk <= 1'b0;
		end else if (state != SST_LOCKED) begin
			// the locking sync counts for its own sub-block
			winSeen <= accept;
			missCnt <= '0;
			blockSyncOk <= 1'b0;
		end else if (boundary) begin
			winSeen <= 1'b0;
			blockSyncOk <= winSeen || accept;
			if (winSeen || accept) begin
				missCnt <= '0;
			end else begin
				missCnt <= missCnt + 3'h1;
			end
		end else if (accept) begin
			winSeen <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// start-of-data acquisition span after lock
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			spanCnt <= '0;
			spanOpen <= 1'b0;
			startDataSync <= 1'b0;
			acqTimeout <= 1'b0;
		end else if (!pllLock) begin
			spanCnt <= '0;
			spanOpen <= 1'b1;
			startDataSync <= 1'b0;
			acqTimeout <= 1'b0;
		end else if (spanOpen) begin
			if (state == SST_LOCKED) begin
				spanOpen <= 1'b0;
				startDataSync <= 1'b1;
			end else if (bitValid && bitCnt == CNT_LAST) begin
				spanCnt <= spanCnt + 3'h1;
				if (spanCnt == ACQ_SPAN_BLKS - 3'h1) begin
					spanOpen <= 1'b0;
					acqTimeout <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			inSync <= 1'b0;
			blockStart <= 1'b0;
			syncLost <= 1'b0;
			rewriteInsert <= 1'b0;
		end else begin
			inSync <= (state == SST_LOCKED);
			blockStart <= (state == SST_LOCKED) && bitValid &&
				(bitCnt == EXPECT_POS);
			syncLost <= boundary && !winSeen && !accept &&
				(missCnt == LOSS_MISSES - 3'h1);
			rewriteInsert <= rewriteAvail && addrFieldOk &&
				blockSyncOk && (state == SST_LOCKED);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_lockNeedsHit;
		@(posedge clk_sys) disable iff (!rst_n)
		(state != SST_LOCKED) ##1 (state == SST_LOCKED) |->
			$past(accept) && $past(state == SST_CONFIRM) &&
			$past(bitCnt) == EXPECT_POS;
	endproperty
	a_lockNeedsHit: assert property (p_lockNeedsHit)
		else $error("lock without two hits");

	property p_outsideReject;
		@(posedge clk_sys) disable iff (!rst_n)
		(state == SST_LOCKED && !inWin && bitValid && syncHit) |=>
			!winSeen || $past(winSeen);
	endproperty
	a_outsideReject: assert property (p_outsideReject)
		else $error("sync taken outside window");

	property p_lossAfterFive;
		@(posedge clk_sys) disable iff (!rst_n)
		syncLost |-> $past(missCnt) == 3'h4;
	endproperty
	a_lossAfterFive: assert property (p_lossAfterFive)
		else $error("loss not on fifth miss");

	property p_hitClearsMiss;
		@(posedge clk_sys) disable iff (!rst_n)
		(boundary && accept) |=> missCnt == 3'h0;
	endproperty
	a_hitClearsMiss: assert property (p_hitClearsMiss)
		else $error("miss count not restarted");

	property p_rewriteGate;
		@(posedge clk_sys) disable iff (!rst_n)
		rewriteInsert |-> $past(addrFieldOk) && $past(blockSyncOk);
	endproperty
	a_rewriteGate: assert property (p_rewriteGate)
		else $error("rewrite inserted without clean fields");

	property p_period;
		@(posedge clk_sys) disable iff (!rst_n)
		(bitValid && state == SST_LOCKED && bitCnt == 9'h010) |=>
			bitCnt == 9'h011;
	endproperty
	a_period: assert property (p_period)
		else $error("bit counter not free running");

	property p_realign;
		@(posedge clk_sys) disable iff (!rst_n)
		(accept && pllLock && state == SST_SEARCH) |=>
			bitCnt == 9'h001 && state == SST_CONFIRM;
	endproperty
	a_realign: assert property (p_realign)
		else $error("no realign on sync after loss");

	property p_lostSearch;
		@(posedge clk_sys) disable iff (!rst_n)
		syncLost |-> state == SST_SEARCH ##1 !inSync;
	endproperty
	a_lostSearch: assert property (p_lostSearch)
		else $error("search not resumed after loss");

	property p_exactMatch;
		@(posedge clk_sys) disable iff (!rst_n)
		accept |-> syncHit;
	endproperty
	a_exactMatch: assert property (p_exactMatch)
		else $error("sync accepted with bit errors");

	c_lock: cover property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(inSync));
	c_lost: cover property (@(posedge clk_sys) disable iff (!rst_n)
		syncLost);
	c_rewrite: cover property (@(posedge clk_sys) disable iff (!rst_n)
		rewriteInsert);
	c_timeout: cover property (@(posedge clk_sys) disable iff (!rst_n)
		acqTimeout);
endmodule
